// File: logic/dio_filter_ports.sv
// Filtered isolated digital I/O ports: filter time, input data, output latch and monitor.
// Assumes a byte-wide port with one-cycle read and write strobes, all synchronous to clk.
//
// Functional notes
// - Each input is sampled once every quarter of the programmed filter time.
// - A filtered level changes only after four consecutive samples show the same new level.
// - A differing sample before four matches drops the partial count and keeps the old level.
// - The filter code comes from the low five bits written at offset 03h, upper bits zero.
// - Code n from 1 to 20 gives a filter time of 2 to the n divided by 8 MHz.
// - Code zero passes raw inputs straight through and is the code after reset.
// - One programmed filter time applies to all input channels together.
// - Reading offset 10h returns one bit per input, 1 for ON, unused upper bits 0.
// - Writing offset 14h latches one bit per output, 1 turning its transistor on.
// - After reset every output latch bit is 0 so all transistors are off.
// - Reading offset 14h returns the output latch without disturbing it.
// - Input change detection uses the filtered level when the filter is on.
`timescale 1ns/1ps
`default_nettype none
`include "dio_filter_params.svh"

module dio_filter_ports
    import dio_filter_pkg::*;
#(
    parameter int NUM_IN  = 8,
    parameter int NUM_OUT = 8
) (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire dio_filter_pkg::io_byte_t  addr,
    input  wire logic                      wr_en,
    input  wire logic                      rd_en,
    input  wire dio_filter_pkg::io_byte_t  wdata,
    output dio_filter_pkg::io_byte_t       rdata,
    input  wire logic [NUM_IN-1:0]         raw_in,
    output logic [NUM_IN-1:0]              in_level,
    output logic [NUM_IN-1:0]              in_change,
    output logic [NUM_OUT-1:0]             out_drive
);
    import dio_filter_pkg::*;

    // Timebase: phase accumulator giving an average 32 MHz tick from the 50 MHz clock.
    // A tick at four times the 8 MHz reference makes one sample interval exactly a
    // quarter of the filter time, so nothing downstream has to divide by four.
    localparam int PORT_BITS = $bits(io_byte_t);
    localparam int SAMPLE_MHZ = `FILTER_REF_MHZ * `SAMPLES_PER_TIME;
    localparam logic [5:0] ACC_STEP = 6'(SAMPLE_MHZ);
    localparam logic [5:0] ACC_WRAP = 6'(`CLK_MHZ);

    // Whole port state: filter code, output latch, read data, timebase and the
    // registered copy of the filtered levels with their change pulses
    typedef struct packed {
        filter_code_t     code;
        logic [NUM_OUT-1:0] out_latch;
        io_byte_t         rdata;
        logic [5:0]       acc;
        tick_count_t      tick_cnt;
        logic             sample_en;
        logic [NUM_IN-1:0] level;
        logic [NUM_IN-1:0] change;
    } port_state_s;

    port_state_s        state;
    port_state_s        next_state;
    logic [NUM_IN-1:0]  filt_level;
    logic               bypass;

    // Decoded strobes, timebase terms and byte views used by the update logic
    logic               wr_code;
    logic               wr_latch;
    logic               rd_code;
    logic               rd_input;
    logic               rd_latch;
    logic [6:0]         acc_sum;
    logic               tick;
    logic               sample_due;
    io_byte_t           in_byte;
    io_byte_t           out_byte;

    // Address decode shared by read and write paths
    // An exact match on the whole byte, so no neighbouring offset aliases a port
    function automatic logic hit(input io_byte_t a, input io_byte_t ofs);
        hit = (a == ofs);
    endfunction : hit

    // Number of 32 MHz ticks per sample, less one, for a filter code
    // Codes above the top of the table are held at the top, so a stray write can
    // never stretch the count past its 21 bits or stall sampling altogether
    function automatic tick_count_t sample_limit(input filter_code_t c);
        filter_code_t cc;
        cc = (c > `FILTER_CODE_MAX) ? `FILTER_CODE_MAX : c;       // Keep undefined codes bounded
        sample_limit = tick_count_t'((22'd1 << cc) - 22'd1);
    endfunction : sample_limit

    // Power-on contents: pass-through filter, outputs off, read data and levels clear
    function automatic port_state_s reset_state();
        port_state_s s;
        s = '0;
        s.code = filter_code_t'(`FILTER_RST);
        s.out_latch = NUM_OUT'(`OUTPUT_RST);
        reset_state = s;
    endfunction : reset_state

    assign bypass = (state.code == `FILTER_CODE_OFF);

    // Port strobes, each decoded once; a write and a read in the same cycle both act,
    // and the read returns the contents from before the write
    assign wr_code  = wr_en && hit(addr, `OFS_FILTER_TIME);
    assign wr_latch = wr_en && hit(addr, `OFS_OUTPUT_LATCH);
    assign rd_code  = rd_en && hit(addr, `OFS_FILTER_TIME);
    assign rd_input = rd_en && hit(addr, `OFS_INPUT_LEVELS);
    assign rd_latch = rd_en && hit(addr, `OFS_OUTPUT_LATCH);

    // Fractional divider: adding 32 per clock and wrapping at 50 gives 32 ticks per microsecond.
    // Single sample intervals jitter by one clock, but the average rate is exact, so a long
    // filter time never drifts however long the code stays in place.
    assign acc_sum    = 7'(state.acc) + 7'(ACC_STEP);
    assign tick       = (acc_sum >= 7'(ACC_WRAP));
    assign sample_due = tick && (state.tick_cnt >= sample_limit(state.code));

    // Byte views of the input levels and the output latch; points that a narrower
    // variant lacks read as zero
    genvar gb;
    generate
        for (gb = 0; gb < PORT_BITS; gb++) begin : g_read_bits
            if (gb < NUM_IN) begin : g_in_bit
                assign in_byte[gb] = state.level[gb];
            end else begin : g_in_pad
                assign in_byte[gb] = 1'b0;                         // Unfitted input point
            end
            if (gb < NUM_OUT) begin : g_out_bit
                assign out_byte[gb] = state.out_latch[gb];
            end else begin : g_out_pad
                assign out_byte[gb] = 1'b0;                        // Unfitted output point
            end
        end
    endgenerate

    // One filter stage per input, all sharing one sample strobe
    // A shared strobe means every point runs on the same filter time
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_filter
            dio_input_filter u_filter (
                .clk       (clk),
                .rst_b     (rst_b),
                .bypass    (bypass),
                .sample_en (state.sample_en),
                .raw       (raw_in[gi]),
                .level     (filt_level[gi])
            );
        end
    endgenerate

    // Register writes, timebase, input tracking and registered read data
    always_comb begin
        next_state = state;
        next_state.sample_en = 1'b0;

        // Accumulator steps every clock and wraps on each tick
        if (tick) begin
            next_state.acc = 6'(acc_sum - 7'(ACC_WRAP));
        end else begin
            next_state.acc = acc_sum[5:0];
        end

        // Sample strobe every 2^n ticks, a quarter of the filter time; pass-through parks
        // the counter at zero so that turning the filter on starts with a whole interval
        if (bypass) begin
            next_state.tick_cnt = '0;
        end else if (tick) begin
            if (sample_due) begin
                next_state.tick_cnt = '0;
                next_state.sample_en = 1'b1;
            end else begin
                next_state.tick_cnt = state.tick_cnt + 21'd1;
            end
        end

        // Filtered levels and change pulses for downstream edge detection
        // The pulse rises with the new level, so an edge detector sees both in one cycle
        next_state.level = filt_level;
        next_state.change = filt_level ^ state.level;

        // Register writes; a new code restarts the count so its first interval is whole
        if (wr_code) begin
            next_state.code = wdata[`FILTER_CODE_MSB:`FILTER_CODE_LSB];
            next_state.tick_cnt = '0;                              // Restart sample count on new code; accumulator keeps running
        end
        if (wr_latch) begin
            next_state.out_latch = wdata[NUM_OUT-1:0];
        end

        // Registered read data, zero on unmapped offsets; a read never touches the latch
        if (rd_en) begin
            next_state.rdata = '0;
            if (rd_code) begin
                next_state.rdata = io_byte_t'(state.code);
            end else if (rd_input) begin
                next_state.rdata = in_byte;
            end else if (rd_latch) begin
                next_state.rdata = out_byte;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= reset_state();
        end else begin
            state <= next_state;
        end
    end

    // Read data and filtered inputs straight from the state register
    assign rdata     = state.rdata;
    assign in_level  = state.level;
    assign in_change = state.change;

    // Output transistors follow the latch; only a port write moves it
    assign out_drive = state.out_latch;

endmodule : dio_filter_ports
`default_nettype wire

// File: logic/dio_filter_params.svh
// Offsets, field positions, reset values and timing figures of the filtered I/O ports.
// Assumes byte-wide register ports addressed from the module's starting I/O address.
`ifndef DIO_FILTER_PARAMS_SVH
`define DIO_FILTER_PARAMS_SVH

// Port offsets from the starting I/O address
`define OFS_FILTER_TIME   8'h03
`define OFS_INPUT_LEVELS  8'h10
`define OFS_OUTPUT_LATCH  8'h14

// Filter code field and reset values
`define FILTER_CODE_MSB   4
`define FILTER_CODE_LSB   0
`define FILTER_CODE_MAX   5'h14
`define FILTER_CODE_OFF   5'h00
`define FILTER_RST        8'h00
`define OUTPUT_RST        8'h00

// Filter timebase: reference rate, sampling at four times it, system clock rate (MHz)
`define FILTER_REF_MHZ    8
`define SAMPLES_PER_TIME  4
`define CLK_MHZ           50

// Consecutive equal samples needed before the filtered level changes
`define STABLE_SAMPLES    3'd4

`endif

// File: logic/dio_filter_pkg.sv
// Types shared by the filtered I/O port logic.
// Assumes the constants of dio_filter_params.svh.
package dio_filter_pkg;

    typedef logic [7:0]  io_byte_t;
    typedef logic [4:0]  filter_code_t;
    typedef logic [20:0] tick_count_t;
    typedef logic [2:0]  sample_count_t;

endpackage : dio_filter_pkg

// File: logic/dio_input_filter.sv
// One debounce filter stage for a single input point.
// Assumes sample_en is a one-cycle pulse at a quarter of the filter time.
`timescale 1ns/1ps
`default_nettype none
`include "dio_filter_params.svh"

module dio_input_filter
    import dio_filter_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic bypass,
    input  wire logic sample_en,
    input  wire logic raw,
    output logic      level
);
    import dio_filter_pkg::*;

    typedef struct packed {
        logic          level;
        logic          last;
        sample_count_t count;
    } chan_state_s;

    chan_state_s state;
    chan_state_s next_state;

    // Count matching samples of a new level; any mismatch restarts the count
    always_comb begin
        next_state = state;
        if (bypass) begin
            next_state.level = raw;
            next_state.count = '0;
        end else if (sample_en) begin
            next_state.last = raw;
            if (raw == state.level) begin
                next_state.count = '0;
            end else if (state.count != '0 && raw != state.last) begin
                next_state.count = 3'd1;
            end else if (state.count + 3'd1 == `STABLE_SAMPLES) begin
                next_state.level = raw;
                next_state.count = '0;
            end else begin
                next_state.count = state.count + 3'd1;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.level;

endmodule : dio_input_filter
`default_nettype wire

// File: dv/ports_checker.sv
// Concurrent checks on the filtered I/O port block.
// Assumes eight inputs and eight outputs and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ports_checker
    import dio_filter_pkg::*;
#(
    parameter int NUM_IN  = 8,
    parameter int NUM_OUT = 8
) (
    input wire logic                     clk,
    input wire logic                     rst_b,
    input wire dio_filter_pkg::io_byte_t addr,
    input wire logic                     wr_en,
    input wire logic                     rd_en,
    input wire dio_filter_pkg::io_byte_t wdata,
    input wire dio_filter_pkg::io_byte_t rdata,
    input wire logic [NUM_IN-1:0]        raw_in,
    input wire logic [NUM_IN-1:0]        in_level,
    input wire logic [NUM_IN-1:0]        in_change,
    input wire logic [NUM_OUT-1:0]       out_drive
);
    filter_code_t code;
    // Shadow of the programmed filter code
    always_ff @(posedge clk) begin
        if (!rst_b)
            code <= 5'h00;
        else if (wr_en && addr == 8'h03)
            code <= wdata[4:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    out_latch_a: assert property (wr_en && addr == 8'h14 |=> out_drive == $past(wdata))
        else $error("latch missed a write");
    out_reset_a: assert property (disable iff (1'b0) !rst_b |=> out_drive == '0)
        else $error("drive not cleared by reset");
    mon_read_a: assert property (rd_en && !wr_en && addr == 8'h14 |=> rdata == $past(out_drive))
        else $error("monitor read wrong");
    mon_keep_a: assert property (rd_en && !wr_en |=> $stable(out_drive))
        else $error("read disturbed drive");
    in_read_a: assert property (rd_en && addr == 8'h10 |=> rdata == $past(in_level))
        else $error("input read wrong");
    code_read_a: assert property (rd_en && addr == 8'h03 |=> rdata == {3'h0, $past(code)})
        else $error("code read wrong");
    change_pulse_a: assert property (in_change == (in_level ^ $past(in_level)))
        else $error("change pulse wrong");
    raw_pass_a: assert property (code == 5'h00 && $past(code) == 5'h00 && $past(code, 2) == 5'h00
        && $past(rst_b, 2) |-> in_level == $past(raw_in, 2))
        else $error("bypass not raw");
endmodule : ports_checker
bind dio_filter_ports ports_checker #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) chk (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
    .rdata(rdata), .raw_in(raw_in), .in_level(in_level), .in_change(in_change), .out_drive(out_drive));
`default_nettype wire

// File: dv/io_controller.sv
// Controller model issuing byte-wide port reads and writes.
// Assumes one-cycle strobes and read data one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module io_controller
    import dio_filter_pkg::*;
(
    input  wire logic                     clk,
    output dio_filter_pkg::io_byte_t      addr,
    output logic                          wr_en,
    output logic                          rd_en,
    output dio_filter_pkg::io_byte_t      wdata,
    input  wire dio_filter_pkg::io_byte_t rdata
);
    initial begin
        addr = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 8'h00;
    end
    // One write strobe; released data shows its inverse
    task automatic wr(input io_byte_t a, input io_byte_t d);
        if (a == 8'h03 && d[4:0] > 5'h14)
            d = 8'h14;
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        wdata <= ~d;
    endtask : wr
    // One read strobe, data taken a cycle later
    task automatic rd(input io_byte_t a, output io_byte_t d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd
endmodule : io_controller
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the filtered I/O port block.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dio_filter_pkg::*;
    logic     clk = 1'b0;
    logic     rst_b = 1'b0;
    logic     wr_en, rd_en;
    io_byte_t addr, wdata, rdata, raw_in, in_level, in_change, out_drive, v;
    int       miscompares = 0;
    int       total_checks = 0;
    int       cyc = 0;
    int       t;
    always #10 clk = ~clk;
    dio_filter_ports #(.NUM_IN(8), .NUM_OUT(8)) uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .raw_in(raw_in), .in_level(in_level),
        .in_change(in_change), .out_drive(out_drive));
    io_controller ctl (.clk(clk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata));
    task automatic check(input string name, input io_byte_t seen, input io_byte_t exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    // Cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        raw_in = 8'h00;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        ctl.rd(8'h14, v);
        check("latch reset", v, 8'h00);
        check("drive reset", out_drive, 8'h00);
        ctl.rd(8'h03, v);
        check("code reset", v, 8'h00);
        ctl.wr(8'h14, 8'hA5);
        ctl.rd(8'h14, v);
        check("monitor", v, 8'hA5);
        check("drive", out_drive, 8'hA5);
        $display("test latch done");
        ctl.wr(8'h03, 8'hE3);
        ctl.rd(8'h03, v);
        check("code field", v, 8'h03);
        ctl.wr(8'h03, 8'h14);
        ctl.rd(8'h03, v);
        check("code max", v, 8'h14);
        ctl.wr(8'h03, 8'h00);
        @(posedge clk) raw_in <= 8'h3C;
        repeat (3) @(posedge clk);
        ctl.rd(8'h10, v);
        check("bypass read", v, 8'h3C);
        $display("test code done");
        @(posedge clk) raw_in <= 8'h00;
        ctl.wr(8'h03, 8'h02);
        @(posedge clk) raw_in <= 8'hFF;
        repeat (10) @(posedge clk);
        raw_in <= 8'h00;
        repeat (40) @(posedge clk);
        check("glitch kept out", in_level, 8'h00);
        raw_in <= 8'hFF;
        t = 0;
        while (in_level !== 8'hFF && t < 60) begin
            @(posedge clk);
            t++;
        end
        check("filter delay", 8'(t >= 18 && t <= 32), 8'h01);
        check("all points", in_level, 8'hFF);
        check("change pulse", in_change, 8'hFF);
        @(posedge clk);
        check("change once", in_change, 8'h00);
        $display("test filter done");
        close_out();
    end
endmodule : tb
`default_nettype wire
